/* File: hw/clamp_unit.v */
// Combinational evaluator of the four clamp operations.
// Assumes operand, destination and flags are stable for the cycle it is used.
`timescale 1ns/1ns
`include "limit_and_frame_ops_regs.vh"

module clamp_unit (
   input  wire [2:0]  op,
   input  wire        byte_mode,
   input  wire [15:0] dest_in,
   input  wire [15:0] operand,
   input  wire [3:0]  flags_in,
   output reg  [15:0] dest_out,
   output reg  [3:0]  flags_out
);

   reg        load;
   reg        s_less;
   reg        s_more;
   reg        u_less;
   reg        u_more;
   reg        c_in;
   reg        v_in;
   reg        n_in;
   reg        res_zero;
   reg        res_neg;

   always @* begin
      c_in = flags_in[`FLAG_C];
      v_in = flags_in[`FLAG_V];
      n_in = flags_in[`FLAG_N];
      if (byte_mode) begin
         s_less = $signed(operand[7:0]) < $signed(dest_in[7:0]);
         s_more = $signed(operand[7:0]) > $signed(dest_in[7:0]);
         u_less = operand[7:0] < dest_in[7:0];
         u_more = operand[7:0] > dest_in[7:0];
      end else begin
         s_less = $signed(operand) < $signed(dest_in);
         s_more = $signed(operand) > $signed(dest_in);
         u_less = operand < dest_in;
         u_more = operand > dest_in;
      end
      case (op)
         `OP_SIGNED_UPPER:   load = (v_in & n_in) | (~v_in & s_less);
         `OP_SIGNED_LOWER:   load = (v_in & ~n_in) | (~v_in & s_more);
         `OP_UNSIGNED_UPPER: load = c_in | u_less;
         `OP_UNSIGNED_LOWER: load = c_in | u_more;
         default:            load = 1'b0;
      endcase
      if (load) begin
         dest_out = byte_mode ? {8'h00, operand[7:0]} : operand;
      end else if (byte_mode && op == `OP_UNSIGNED_UPPER) begin
         dest_out = {8'h00, dest_in[7:0]};
      end else begin
         dest_out = dest_in;
      end
      res_zero = byte_mode ? (dest_out[7:0] == 8'h00) : (dest_out == 16'h0000);
      res_neg  = byte_mode ? dest_out[7] : dest_out[15];
      flags_out = flags_in;
      if (op == `OP_SIGNED_UPPER || op == `OP_SIGNED_LOWER) begin
         if (load) begin
            flags_out[`FLAG_V] = 1'b0;
            flags_out[`FLAG_C] = 1'b1;
            flags_out[`FLAG_Z] = res_zero;
            flags_out[`FLAG_N] = res_neg;
         end
      end else if (op == `OP_UNSIGNED_UPPER || op == `OP_UNSIGNED_LOWER) begin
         flags_out[`FLAG_C] = 1'b0;
         flags_out[`FLAG_Z] = res_zero;
         flags_out[`FLAG_N] = res_neg;
         if (load) begin
            flags_out[`FLAG_V] = 1'b1;
         end
      end
   end

endmodule

/* File: hw/limit_and_frame_ops.v */
// Execution datapath for address load, clamp and frame-link operations.
// Assumes a register port master that issues one-cycle strobes and that the
// stack memory accepts a write on every cycle the write strobe is high.
//
// What this block does
// - Address load writes source plus sixteen-bit offset; flags untouched.
// - Zero source register selected gives the offset alone.
// - Signed upper clamp loads on V and N, or V clear and operand below.
// - Signed lower clamp loads on V and not N, or V clear and operand above.
// - Signed clamp load clears V, sets C, sets Z and N; else flags kept.
// - Unsigned upper clamp loads on carry or operand below destination.
// - Unsigned lower clamp loads on carry or operand above destination.
// - Unsigned clamps clear C, set Z and N; V set only on load.
// - Byte clamps compare low byte; load clears upper byte.
// - Byte unsigned upper clamp always clears bits 8 to 15.
// - Clamp N comes from bit 7 or bit 15 by size; Z from the low byte or the whole word.
// - Frame link pushes frame pointer, copies stack pointer, adds two.
// - Frame link then adds twice the eight-bit size; flags untouched.
// - Frame link allocates zero to 255 words.
`timescale 1ns/1ns
`include "limit_and_frame_ops_regs.vh"

module limit_and_frame_ops (
   input  wire        clock,
   input  wire        rst_b,
   input  wire [7:0]  address,
   input  wire [15:0] write_data,
   input  wire        write_strobe,
   input  wire        read_strobe,
   output reg  [15:0] read_data,
   output reg         busy,
   output reg         stack_write,
   output reg  [15:0] stack_address,
   output reg  [15:0] stack_data
);

   // ***********************************************
   // Sequencer states
   // ***********************************************
   localparam [2:0] SEQ_IDLE    = 3'h0;
   localparam [2:0] SEQ_EXEC    = 3'h1;
   localparam [2:0] SEQ_PUSH    = 3'h2;
   localparam [2:0] SEQ_ADVANCE = 3'h3;
   localparam [2:0] SEQ_ALLOC   = 3'h4;

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [2:0]  op_q;
   reg         byte_q;
   reg         zero_src_q;
   reg  [15:0] source_q;
   reg  [15:0] dest_q;
   reg  [15:0] dest_d;
   reg  [15:0] operand_q;
   reg  [15:0] offset_q;
   reg  [15:0] frame_ptr_q;
   reg  [15:0] frame_ptr_d;
   reg  [15:0] stack_ptr_q;
   reg  [15:0] stack_ptr_d;
   reg  [3:0]  flags_q;
   reg  [3:0]  flags_d;
   reg         done_q;
   reg  [15:0] read_mux;
   reg         push_d;
   reg  [15:0] alloc_bytes;
   wire [15:0] clamp_dest;
   wire [3:0]  clamp_flags;
   wire        launch;
   wire        sw_write;
   wire        idle;
   wire [2:0]  cmd_op;

   // ***********************************************
   // Decode helpers
   // ***********************************************
   // Decode of an op that goes through the clamp evaluator
   function is_clamp;
      input [2:0] op;
      begin
         is_clamp = (op == `OP_SIGNED_UPPER) || (op == `OP_SIGNED_LOWER) ||
                    (op == `OP_UNSIGNED_UPPER) || (op == `OP_UNSIGNED_LOWER);
      end
   endfunction

   // Strobe qualified by one register address
   function reg_hit;
      input [7:0] addr;
      input [7:0] target;
      input       strobe;
      begin
         reg_hit = strobe && (addr == target);
      end
   endfunction

   assign idle     = (state_q == SEQ_IDLE);
   assign cmd_op   = write_data[`CMD_OP_MSB:`CMD_OP_LSB];
   // A command written while busy is dropped; software polls the busy bit
   assign launch   = reg_hit(address, `ADDR_COMMAND, write_strobe) && idle;
   // Operand writes are blocked while busy so an op sees stable inputs
   assign sw_write = write_strobe && idle;

   clamp_unit u_clamp (
      .op        (op_q),
      .byte_mode (byte_q),
      .dest_in   (dest_q),
      .operand   (operand_q),
      .flags_in  (flags_q),
      .dest_out  (clamp_dest),
      .flags_out (clamp_flags)
   );

   // ***********************************************
   // Sequencer
   // ***********************************************
   always @* begin
      state_d     = state_q;
      dest_d      = dest_q;
      frame_ptr_d = frame_ptr_q;
      stack_ptr_d = stack_ptr_q;
      flags_d     = flags_q;
      push_d      = 1'b0;
      // full 0 to 255 word range
      alloc_bytes = {7'h00, offset_q[7:0], 1'b0};
      case (state_q)
         SEQ_IDLE: begin
            if (launch) begin
               state_d = (cmd_op == `OP_FRAME_LINK) ? SEQ_PUSH : SEQ_EXEC;
            end
         end
         SEQ_EXEC: begin
            if (op_q == `OP_EA_LOAD) begin
               dest_d = zero_src_q ? offset_q : source_q + offset_q;
            end else if (is_clamp(op_q)) begin
               dest_d  = clamp_dest;
               flags_d = clamp_flags;
            end
            // Unused op codes fall through as one-cycle no-ops
            state_d = SEQ_IDLE;
         end
         SEQ_PUSH: begin
            push_d  = 1'b1;
            state_d = SEQ_ADVANCE;
         end
         SEQ_ADVANCE: begin
            frame_ptr_d = stack_ptr_q;
            stack_ptr_d = stack_ptr_q + `STACK_STEP;
            state_d     = SEQ_ALLOC;
         end
         SEQ_ALLOC: begin
            stack_ptr_d = stack_ptr_q + alloc_bytes;
            state_d     = SEQ_IDLE;
         end
         default: begin
            state_d = SEQ_IDLE;
         end
      endcase
   end

   // ***********************************************
   // Sequencer state and busy output
   // ***********************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= SEQ_IDLE;
         busy    <= 1'b0;
      end else begin
         state_q <= state_d;
         // From the next state, so busy rises on the launch edge itself
         busy    <= (state_d != SEQ_IDLE);
      end
   end

   // ***********************************************
   // Command latch and completion flag
   // ***********************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         op_q       <= `OP_EA_LOAD;
         byte_q     <= 1'b0;
         zero_src_q <= 1'b0;
         done_q     <= 1'b0;
      end else if (launch) begin
         op_q       <= cmd_op;
         byte_q     <= write_data[`CMD_BYTE_BIT];
         zero_src_q <= write_data[`CMD_ZERO_SRC_BIT];
         done_q     <= 1'b0;
      end else if (!idle && state_d == SEQ_IDLE) begin
         done_q <= 1'b1;
      end
   end

   // ***********************************************
   // Operand registers, written by software only
   // ***********************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         source_q  <= `RESET_WORD;
         operand_q <= `RESET_WORD;
         offset_q  <= `RESET_WORD;
      end else begin
         if (reg_hit(address, `ADDR_SOURCE, sw_write)) begin
            source_q <= write_data;
         end
         if (reg_hit(address, `ADDR_OPERAND, sw_write)) begin
            operand_q <= write_data;
         end
         if (reg_hit(address, `ADDR_OFFSET, sw_write)) begin
            offset_q <= write_data;
         end
      end
   end

   // ***********************************************
   // Destination and status flags
   // ***********************************************
   // Software and results never collide: software is locked out while busy
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dest_q  <= `RESET_WORD;
         flags_q <= `RESET_FLAGS;
      end else begin
         if (reg_hit(address, `ADDR_DEST, sw_write)) begin
            dest_q <= write_data;
         end else begin
            dest_q <= dest_d;
         end
         // flags untouched by link and address load
         if (reg_hit(address, `ADDR_FLAGS, sw_write)) begin
            flags_q <= write_data[3:0];
         end else begin
            flags_q <= flags_d;
         end
      end
   end

   // ***********************************************
   // Frame and stack pointers
   // ***********************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         frame_ptr_q <= `RESET_WORD;
         stack_ptr_q <= `RESET_WORD;
      end else begin
         if (reg_hit(address, `ADDR_FRAME_PTR, sw_write)) begin
            frame_ptr_q <= write_data;
         end else begin
            frame_ptr_q <= frame_ptr_d;
         end
         // Pointers wrap at 16 bits; no check that the frame fits
         if (reg_hit(address, `ADDR_STACK_PTR, sw_write)) begin
            stack_ptr_q <= write_data;
         end else begin
            stack_ptr_q <= stack_ptr_d;
         end
      end
   end

   // ***********************************************
   // Stack write port
   // ***********************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stack_write   <= 1'b0;
         stack_address <= `RESET_WORD;
         stack_data    <= `RESET_WORD;
      end else begin
         stack_write <= push_d;
         // Address and data hold between pushes for the stack memory
         if (push_d) begin
            stack_address <= stack_ptr_q;
            stack_data    <= frame_ptr_q;
         end
      end
   end

   // ***********************************************
   // Register read port
   // ***********************************************
   always @* begin
      case (address)
         `ADDR_COMMAND:   read_mux = {11'h000, zero_src_q, byte_q, op_q};
         `ADDR_SOURCE:    read_mux = source_q;
         `ADDR_DEST:      read_mux = dest_q;
         `ADDR_OPERAND:   read_mux = operand_q;
         `ADDR_OFFSET:    read_mux = offset_q;
         `ADDR_FRAME_PTR: read_mux = frame_ptr_q;
         `ADDR_STACK_PTR: read_mux = stack_ptr_q;
         `ADDR_FLAGS:     read_mux = {12'h000, flags_q};
         `ADDR_STATE:     read_mux = {14'h0000, done_q, busy};
         default:         read_mux = 16'h0000;
      endcase
   end

   // Unmapped addresses read zero; data stand only in the cycle after the strobe
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         read_data <= `RESET_WORD;
      end else if (read_strobe) begin
         read_data <= read_mux;
      end else begin
         read_data <= 16'h0000;
      end
   end

endmodule

/* File: hw/limit_and_frame_ops_regs.vh */
// Register map, field positions, op codes and reset values of the
// limit and frame datapath. Included by both design files.
`ifndef LIMIT_AND_FRAME_OPS_REGS_VH
`define LIMIT_AND_FRAME_OPS_REGS_VH

// ***********************************************
// Register byte addresses
// ***********************************************
`define ADDR_COMMAND      8'h00
`define ADDR_SOURCE       8'h04
`define ADDR_DEST         8'h08
`define ADDR_OPERAND      8'h0C
`define ADDR_OFFSET       8'h10
`define ADDR_FRAME_PTR    8'h14
`define ADDR_STACK_PTR    8'h18
`define ADDR_FLAGS        8'h1C
`define ADDR_STATE        8'h20

// ***********************************************
// Command fields
// ***********************************************
`define CMD_OP_LSB        0
`define CMD_OP_MSB        2
`define CMD_BYTE_BIT      3
`define CMD_ZERO_SRC_BIT  4

// ***********************************************
// Op codes
// ***********************************************
`define OP_EA_LOAD        3'h0
`define OP_SIGNED_UPPER   3'h1
`define OP_SIGNED_LOWER   3'h2
`define OP_UNSIGNED_UPPER 3'h3
`define OP_UNSIGNED_LOWER 3'h4
`define OP_FRAME_LINK     3'h5

// ***********************************************
// Status flag bit positions
// ***********************************************
`define FLAG_C            0
`define FLAG_V            1
`define FLAG_Z            2
`define FLAG_N            3

// ***********************************************
// State register bits
// ***********************************************
`define STATE_BUSY_BIT    0
`define STATE_DONE_BIT    1

// ***********************************************
// Reset values and constants
// ***********************************************
`define RESET_WORD        16'h0000
`define RESET_FLAGS       4'h0
`define STACK_STEP        16'h0002
`define EXEC_CYCLES       1

`endif

/* File: verif/limit_frame_monitor.sv */
// Port checker for the limit and frame datapath.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module limit_frame_monitor (
   input wire        clock,
   input wire        rst_b,
   input wire [7:0]  address,
   input wire [15:0] write_data,
   input wire        write_strobe,
   input wire        read_strobe,
   input wire [15:0] read_data,
   input wire        busy,
   input wire        stack_write,
   input wire [15:0] stack_address,
   input wire [15:0] stack_data
);
   // ********************
   // Launch decode
   // ********************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Writes while busy are dropped, so only idle writes launch
   wire launch = write_strobe && address == 8'h00 && !busy;
   wire link   = launch && write_data[2:0] == 3'h5;
   wire clamp  = launch && write_data[2:0] != 3'h0 && write_data[2:0] < 3'h5;
   sequence s_one_op;
      busy ##1 !busy;
   endsequence
   sequence s_link_op;
      busy ##1 busy && stack_write ##1 busy ##1 !busy;
   endsequence
   chk_ea_one_cycle:
      assert property (launch && write_data[2:0] == 3'h0 |=> s_one_op) else $error("address load timing");
   chk_clamp_one_cycle:
      assert property (clamp |=> s_one_op) else $error("clamp timing");
   chk_link_sequence:
      assert property (link |=> s_link_op) else $error("frame link step order");
   chk_link_any_size:
      assert property (link |-> ##4 !busy) else $error("frame link length");
   chk_push_once:
      assert property (stack_write |=> !stack_write) else $error("push longer than one cycle");
   chk_push_cause:
      assert property (stack_write |-> $past(link, 2)) else $error("push without frame link");
   chk_push_fields_hold:
      assert property (!stack_write |-> $stable(stack_address) && $stable(stack_data))
         else $error("push fields moved");
   chk_busy_cause:
      assert property ($rose(busy) |-> $past(launch)) else $error("busy without command");
   chk_read_one_cycle:
      assert property (!$past(read_strobe) |-> read_data == 16'h0000) else $error("stray read data");
endmodule
bind limit_and_frame_ops limit_frame_monitor u_monitor (
   .clock(clock), .rst_b(rst_b), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
   .busy(busy), .stack_write(stack_write), .stack_address(stack_address), .stack_data(stack_data)
);

/* File: verif/tb.sv */
// Self-checking bench for the limit and frame datapath.
// Assumes the shared register header and a 100 MHz clock.
`timescale 1ns/1ns
`include "limit_and_frame_ops_regs.vh"
module tb;
   reg         clock = 1'b0;
   reg         rst_b = 1'b0;
   reg  [7:0]  address = 8'h00;
   reg  [15:0] write_data = 16'h0000;
   reg         write_strobe = 1'b0;
   reg         read_strobe = 1'b0;
   wire [15:0] read_data;
   wire        busy;
   wire        stack_write;
   wire [15:0] stack_address;
   wire [15:0] stack_data;
   reg  [15:0] got;
   integer     failures = 0;
   integer     num_checks = 0;
   integer     cycles = 0;
   integer     pushes = 0;
   always #5 clock = ~clock;
   limit_and_frame_ops u_dut (
      .clock(clock), .rst_b(rst_b), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .busy(busy), .stack_write(stack_write), .stack_address(stack_address), .stack_data(stack_data)
   );
   // ********************
   // Bus tasks
   // ********************
   task check(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge clock);
         address <= a;
         write_data <= d;
         write_strobe <= 1'b1;
         @(posedge clock);
         write_strobe <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge clock);
         address <= a;
         read_strobe <= 1'b1;
         @(posedge clock);
         read_strobe <= 1'b0;
         #1 got = read_data;
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         #1;
         while (busy !== 1'b0 && n < 20) begin
            @(posedge clock);
            #1 n = n + 1;
         end
         check({15'h0000, busy}, 16'h0000);
      end
   endtask
   task run(input [15:0] cmd);
      begin
         wr(`ADDR_COMMAND, cmd);
         wait_idle;
      end
   endtask
   // Fields: cmd, dest, operand, flags in, dest out, flags out
   task clamp(input [71:0] v);
      begin
         wr(`ADDR_DEST, v[55:40]);
         wr(`ADDR_OPERAND, v[39:24]);
         wr(`ADDR_FLAGS, {12'h000, v[23:20]});
         run(v[71:56]);
         rd(`ADDR_DEST);
         check(got, v[19:4]);
         rd(`ADDR_FLAGS);
         check(got, {12'h000, v[3:0]});
      end
   endtask
   task final_report;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   always @(posedge clock) begin
      if (stack_write === 1'b1)
         pushes <= pushes + 1;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures = failures + 1;
         $display("mismatch at %0t: timeout", $time);
         final_report;
      end
   end
   // ********************
   // Tests
   // ********************
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      wr(`ADDR_SOURCE, 16'h1234);
      wr(`ADDR_OFFSET, 16'h0100);
      wr(`ADDR_FLAGS, 16'h000F);
      run(16'h0000);
      rd(`ADDR_DEST);
      check(got, 16'h1334);
      rd(`ADDR_FLAGS);
      check(got, 16'h000F);
      run(16'h0010);
      rd(`ADDR_DEST);
      check(got, 16'h0100);
      rd(8'h24);
      check(got, 16'h0000);
      clamp(72'h00010005FFFE0FFFE9);
      clamp(72'h000100050007400054);
      clamp(72'h000100050009A00091);
      clamp(72'h000100050001200052);
      clamp(72'h000200050000200005);
      clamp(72'h000200050007A0005A);
      clamp(72'h000912803381012800);
      clamp(72'h0009120533F0000F09);
      clamp(72'h000A12053310000101);
      clamp(72'h000300050003000032);
      clamp(72'h000300050009E00052);
      clamp(72'h00030005800018000A);
      clamp(72'h000B12050009000050);
      clamp(72'h000B12000010000004);
      clamp(72'h000400050003800050);
      clamp(72'h000C12050003012050);
      clamp(72'h000C1205008000080A);
      wr(`ADDR_FRAME_PTR, 16'h4000);
      wr(`ADDR_STACK_PTR, 16'h3000);
      wr(`ADDR_OFFSET, 16'h12FF);
      wr(`ADDR_FLAGS, 16'h0005);
      run(16'h0005);
      check(pushes[15:0], 16'h0001);
      check(stack_address, 16'h3000);
      check(stack_data, 16'h4000);
      rd(`ADDR_FRAME_PTR);
      check(got, 16'h3000);
      rd(`ADDR_STACK_PTR);
      check(got, 16'h3200);
      rd(`ADDR_FLAGS);
      check(got, 16'h0005);
      wr(`ADDR_OFFSET, 16'h0000);
      wr(`ADDR_COMMAND, 16'h0005);
      // Second command lands while busy and must be dropped
      wr(`ADDR_COMMAND, 16'h0001);
      wait_idle;
      check(pushes[15:0], 16'h0002);
      check(stack_address, 16'h3200);
      check(stack_data, 16'h3000);
      rd(`ADDR_STACK_PTR);
      check(got, 16'h3202);
      rd(`ADDR_COMMAND);
      check(got, 16'h0005);
      // Unused op code: nothing may move
      run(16'h0006);
      rd(`ADDR_STACK_PTR);
      check(got, 16'h3202);
      rd(`ADDR_FLAGS);
      check(got, 16'h0005);
      // Reset while idle after the last op clears outputs and registers
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      #1 check(stack_address, 16'h0000);
      check(stack_data, 16'h0000);
      check({15'h0000, busy}, 16'h0000);
      @(posedge clock);
      rst_b <= 1'b1;
      rd(`ADDR_STACK_PTR);
      check(got, 16'h0000);
      rd(`ADDR_FRAME_PTR);
      check(got, 16'h0000);
      final_report;
   end
endmodule
